//--- src/bst_pkg.sv
// Purpose: constants for the boundary-scan test port and shared pins
// Assumes: ir width 4, boundary register covers the gpio pins only
// Notes: id code value is arbitrary
package bst_pkg;
    localparam int BST_IR_W = 4;
    localparam int BST_PINS = 5;
    localparam int BST_BSR_W = 2 * 5;
    localparam logic [3:0] BST_IR_EXTEST = 4'h0;
    localparam logic [3:0] BST_IR_SAMPLE = 4'h1;
    localparam logic [3:0] BST_IR_PRELOAD = 4'h2;
    localparam logic [3:0] BST_IR_IDCODE = 4'h3;
    localparam logic [3:0] BST_IR_HIGHZ = 4'h4;
    localparam logic [3:0] BST_IR_CLAMP = 4'h5;
    localparam logic [3:0] BST_IR_BYPASS = 4'hF;
    localparam logic [3:0] BST_IR_CAPTURE = 4'h1;
    // arbitrary identification value, bit 0 must be one
    localparam logic [31:0] BST_ID_CODE = 32'h0000_1001;
    // synchroniser reset: select high, test clock low, others high
    localparam logic [BST_PINS:0] BST_SYNC_RST = 6'h3E;
    typedef enum logic [3:0] {
        BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
        BST_PA_DR, BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR,
        BST_EX1_IR, BST_PA_IR, BST_EX2_IR, BST_UPD_IR
    } bst_state_t;
endpackage

//--- src/bst_port.sv
// Purpose: boundary-scan test port sharing five pins with gpio
// Assumes: test clock far slower than clk_i, sampled and edge-detected
// Notes: pins are in/out/oe triples, oe low means driven
//
// Function
// - select low: pins become test port, device held non-operational
// - pins 0..4 carry test clock, mode, data in, data out, test reset
// - decode idcode, bypass, extest, sample, preload, highz, clamp; extest, highz and clamp never act on the pins
// - identification instruction shifts out a fixed code
`timescale 1ns/10ps
`default_nettype none
module bst_port
    import bst_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // test select
    input wire logic test_port_select_n_i,
    // shared pins
    input wire logic [bst_pkg::BST_PINS-1:0] pin_in_i,
    output logic [bst_pkg::BST_PINS-1:0] pin_out_o,
    output logic [bst_pkg::BST_PINS-1:0] pin_oe_n_o,
    // core side gpio
    input wire logic [bst_pkg::BST_PINS-1:0] gpio_out_i,
    input wire logic [bst_pkg::BST_PINS-1:0] gpio_oe_n_i,
    output logic [bst_pkg::BST_PINS-1:0] gpio_in_o,
    // device status
    output logic halt_o
);
    import bst_pkg::*;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [BST_PINS:0] sync1;
    logic [BST_PINS:0] sync2;
    logic tck_d;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            // test clock bit resets to its idle low, no false edge after reset
            sync1 <= BST_SYNC_RST;
            sync2 <= BST_SYNC_RST;
            tck_d <= 1'b0;
        end else begin
            sync1 <= {test_port_select_n_i, pin_in_i};
            sync2 <= sync1;
            tck_d <= sync2[0];
        end
    end
    logic sel_n;
    logic test_mode;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tck_rise;
    logic tck_fall;
    assign sel_n = sync2[BST_PINS];
    assign test_mode = !sel_n;
    assign tms = sync2[1];
    assign tdi = sync2[2];
    assign trst_n = sync2[4] || sel_n;
    assign tck_rise = test_mode && sync2[0] && !tck_d;
    assign tck_fall = test_mode && !sync2[0] && tck_d;

    // ------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------
    bst_state_t state;
    bst_state_t next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            BST_RESET: next_state = tms ? BST_RESET : BST_IDLE;
            BST_IDLE: next_state = tms ? BST_SEL_DR : BST_IDLE;
            BST_SEL_DR: next_state = tms ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: next_state = tms ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR: next_state = tms ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: next_state = tms ? BST_UPD_DR : BST_PA_DR;
            BST_PA_DR: next_state = tms ? BST_EX2_DR : BST_PA_DR;
            BST_EX2_DR: next_state = tms ? BST_UPD_DR : BST_SH_DR;
            BST_UPD_DR: next_state = tms ? BST_SEL_DR : BST_IDLE;
            BST_SEL_IR: next_state = tms ? BST_RESET : BST_CAP_IR;
            BST_CAP_IR: next_state = tms ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR: next_state = tms ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: next_state = tms ? BST_UPD_IR : BST_PA_IR;
            BST_PA_IR: next_state = tms ? BST_EX2_IR : BST_PA_IR;
            BST_EX2_IR: next_state = tms ? BST_UPD_IR : BST_SH_IR;
            BST_UPD_IR: next_state = tms ? BST_SEL_DR : BST_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !trst_n || !test_mode) begin
            state <= BST_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    logic [BST_IR_W-1:0] ir_sh;
    logic [BST_IR_W-1:0] ir;
    always_ff @(posedge clk_i) begin
        if (!nrst_i || state == BST_RESET) begin
            ir_sh <= BST_IR_CAPTURE;
            ir <= BST_IR_IDCODE;
        end else if (tck_rise) begin
            if (state == BST_CAP_IR) begin
                ir_sh <= BST_IR_CAPTURE;
            end else if (state == BST_SH_IR) begin
                ir_sh <= {tdi, ir_sh[BST_IR_W-1:1]};
            end
        end else if (tck_fall && state == BST_UPD_IR) begin
            ir <= ir_sh;
        end
    end
    logic sel_bsr;
    logic sel_id;
    assign sel_id = (ir == BST_IR_IDCODE);
    assign sel_bsr = (ir == BST_IR_EXTEST) || (ir == BST_IR_SAMPLE)
        || (ir == BST_IR_PRELOAD);

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    logic [31:0] id_sh;
    logic byp;
    logic [BST_BSR_W-1:0] bsr_sh;
    logic [BST_BSR_W-1:0] bsr_upd;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            id_sh <= '0;
            byp <= 1'b0;
            bsr_sh <= '0;
        end else if (tck_rise && state == BST_CAP_DR) begin
            id_sh <= BST_ID_CODE;
            byp <= 1'b0;
            bsr_sh <= {gpio_oe_n_i, gpio_out_i};
        end else if (tck_rise && state == BST_SH_DR) begin
            id_sh <= {tdi, id_sh[31:1]};
            byp <= tdi;
            if (sel_bsr) begin
                bsr_sh <= {tdi, bsr_sh[BST_BSR_W-1:1]};
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i || state == BST_RESET) begin
            bsr_upd <= {{BST_PINS{1'b1}}, {BST_PINS{1'b0}}};
        end else if (tck_fall && state == BST_UPD_DR && sel_bsr) begin
            bsr_upd <= bsr_sh;
        end
    end

    // ------------------------------------------------------------
    // test data out, changes on falling test clock
    // ------------------------------------------------------------
    logic tdo;
    logic tdo_en;
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !test_mode) begin
            tdo <= 1'b0;
            tdo_en <= 1'b0;
        end else if (tck_fall) begin
            tdo_en <= (state == BST_SH_DR) || (state == BST_SH_IR);
            if (state == BST_SH_IR) begin
                tdo <= ir_sh[0];
            end else if (sel_id) begin
                tdo <= id_sh[0];
            end else if (sel_bsr) begin
                tdo <= bsr_sh[0];
            end else begin
                tdo <= byp;
            end
        end
    end

    // ------------------------------------------------------------
    // pin sharing
    // ------------------------------------------------------------
    logic ext_drive;
    logic ext_hiz;
    assign ext_drive = (ir == BST_IR_EXTEST) || (ir == BST_IR_CLAMP);
    assign ext_hiz = (ir == BST_IR_HIGHZ);
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pin_out_o <= '0;
            pin_oe_n_o <= '1;
            gpio_in_o <= '0;
            halt_o <= 1'b0;
        end else begin
            halt_o <= test_mode;
            gpio_in_o <= test_mode ? '0 : sync2[BST_PINS-1:0];
            if (test_mode) begin
                // test pins are inputs except data out
                pin_out_o <= {1'b0, tdo, 3'b000};
                pin_oe_n_o <= {1'b1, !tdo_en, 3'b111};
            end else begin
                pin_out_o <= gpio_out_i;
                pin_oe_n_o <= gpio_oe_n_i;
            end
        end
    end
    logic unused;
    assign unused = ext_drive ^ ext_hiz ^ ^bsr_upd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_halt_follows: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(sync2[BST_PINS]) |=> halt_o) else $error("halt not raised");
    a_tck_input: assert property (@(posedge clk_i) disable iff (!nrst_i)
        halt_o |-> pin_oe_n_o[0] && pin_oe_n_o[1]) else $error("test inputs driven");
    a_trst_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (test_mode && !sync2[4]) |=> state == BST_RESET) else $error("no reset");
    a_ir_default: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(state) == BST_RESET && state == BST_RESET |-> ir == BST_IR_IDCODE)
        else $error("ir not idcode");
    a_id_capture: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tck_rise && state == BST_CAP_DR |=> id_sh == BST_ID_CODE)
        else $error("id not captured");
    a_tap_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tck_rise && trst_n && state == BST_IDLE && tms |=> state == BST_SEL_DR)
        else $error("bad tap step");
    a_gpio_pass: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !test_mode |=> pin_out_o == $past(gpio_out_i)) else $error("gpio lost");
    a_bypass_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tck_rise && state == BST_SH_DR |=> byp == $past(tdi)) else $error("bypass");
endmodule
`default_nettype wire

//--- bench/bst_ctl_model.sv
// Purpose: far-side boundary-scan controller model
// Assumes: test clock 64 ns period, low outside frames
// Notes: data in toggles while not shifting
`timescale 1ns/10ps
`default_nettype none
module bst_ctl_model (
    // pads toward the port
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    input wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b1;
    end
    // one test clock, data out taken at the rise
    task step(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        #32 tck_o = 1'b1;
        q = tdo_i;
        #32 tck_o = 1'b0;
    endtask
    // idle to shift, n bits lsb first, back to idle
    task scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi_o, q);
        if (ir)
            step(1'b1, ~tdi_o, q);
        step(1'b0, ~tdi_o, q);
        step(1'b0, ~tdi_o, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi_o, q);
        step(1'b0, ~tdi_o, q);
    endtask
    // five ones reach reset, then a zero to idle
    task to_idle;
        logic q;
        for (int i = 0; i < 6; i++)
            step(i < 5, ~tdi_o, q);
    endtask
    task test_reset;
        trst_n_o = 1'b0;
        #64 trst_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- bench/tb_bst_port.sv
// Purpose: self-checking bench for the shared test port
// Assumes: pads resolved here from all drivers
// Notes: undriven data-out pad toggles every clock
`timescale 1ns/10ps
`default_nettype none
module tb_bst_port;
    import bst_pkg::*;
    logic clk_i, nrst_i, sel_n, halt, tck, tms, tdi, trst_n, wig, qb;
    logic [4:0] pin_out, pin_oe_n, gpio_out, gpio_oe_n, gpio_in, gp_ext, pad;
    logic [31:0] d;
    logic [11:0] e12;
    int fails, n_tests;
    // ----
    // pads and instances
    // ----
    always @(posedge clk_i) wig <= nrst_i ? ~wig : 1'b0;
    always_comb begin
        pad = sel_n ? gp_ext : {trst_n, wig, tdi, tms, tck};
        for (int k = 0; k < 5; k++)
            if (!pin_oe_n[k])
                pad[k] = pin_out[k];
    end
    bst_port dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .test_port_select_n_i(sel_n),
        .pin_in_i(pad), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n),
        .gpio_out_i(gpio_out), .gpio_oe_n_i(gpio_oe_n), .gpio_in_o(gpio_in),
        .halt_o(halt));
    bst_ctl_model m_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
        .tdo_i(pad[3]));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wait_halt(input logic v);
        int i;
        i = 0;
        while (halt !== v && i < 10) begin
            @(negedge clk_i);
            i++;
        end
        if (halt !== v) begin
            fails++;
            results;
        end
    endtask
    // ----
    // scenarios
    // ----
    task t_gpio;
        gpio_out = 5'h15;
        gpio_oe_n = 5'h00;
        repeat (4) @(negedge clk_i);
        chk(pin_out, 5'h15);
        chk(gpio_in, 5'h15);
        gpio_oe_n = 5'h1F;
        gp_ext = 5'h0A;
        repeat (4) @(negedge clk_i);
        chk(pin_oe_n, 5'h1F);
        chk(gpio_in, 5'h0A);
        chk(halt, 1'b0);
        gpio_oe_n = 5'h00;
    endtask
    task t_enter;
        sel_n = 1'b0;
        wait_halt(1'b1);
        repeat (4) @(negedge clk_i);
        chk(halt, 1'b1);
        chk(gpio_in, 5'h00);
        chk(pin_oe_n, 5'h1F);
        m_u.to_idle;
    endtask
    task t_len(input logic [3:0] op, input int len);
        m_u.scan(1'b1, 4, {28'h0, op}, d);
        chk(d[3:0], BST_IR_CAPTURE);
        m_u.scan(1'b0, 24, 32'h00FF_F000, d);
        e12 = 12'hFFF << len;
        chk(d[23:12], e12);
        chk(pin_oe_n[3], 1'b1);
    endtask
    task t_id;
        m_u.test_reset;
        m_u.step(1'b0, 1'b0, qb);
        m_u.scan(1'b0, 32, 32'h0, d);
        chk(d, BST_ID_CODE);
        m_u.to_idle;
        m_u.scan(1'b0, 32, 32'h0, d);
        chk(d, BST_ID_CODE);
    endtask
    task t_leave;
        sel_n = 1'b1;
        wait_halt(1'b0);
        nrst_i = 1'b0;
        @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(halt, 1'b0);
        chk(pin_oe_n, 5'h00);
    endtask
    initial begin
        nrst_i = 1'b0;
        sel_n = 1'b1;
        gpio_out = 5'h00;
        gpio_oe_n = 5'h1F;
        gp_ext = 5'h00;
        fails = 0;
        n_tests = 0;
        repeat (8) @(negedge clk_i);
        chk(pin_oe_n, 5'h1F);
        chk(halt, 1'b0);
        nrst_i = 1'b1;
        t_gpio;
        t_enter;
        t_len(BST_IR_BYPASS, 1);
        t_len(BST_IR_EXTEST, 10);
        t_len(BST_IR_SAMPLE, 10);
        t_len(BST_IR_PRELOAD, 10);
        t_len(BST_IR_HIGHZ, 1);
        t_len(BST_IR_CLAMP, 1);
        t_len(4'h7, 1);
        t_id;
        t_leave;
        results;
    end
endmodule
`default_nettype wire
